// File: ptp_trigger_event_timestamp.sv
// Purpose: Time triggers onto GPIO pins and GPIO event timestamp queue
// Assumes: now comes from the precision clock; gpio_in is synchronous to clk
// Notes: Avalon-MM slave, every access answers one cycle after it is raised
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "ptp_tev_defines.svh"
// Notes on behaviour
// - Trigger modes: edge, single pulse, periodic
// - Trigger fires when time equals activation time
// - Eight triggers, each routable to any pin
// - Triggers sharing a pin are ORed
// - Time and width held apart from config
// - Pulse-per-second built from periodic trigger
// - Events captured on rise, fall or both
// - Eight event channels, any input pin
// - Timestamps queued, up to eight entries
// - Event ready set while queue nonempty
// - Status shows channel, direction, missed events
// - Interrupt on shared pin or chosen GPIO
// - Twelve general-purpose pins serve all uses
// - Time is seconds, nanoseconds, fractions
// - All logic on the reference clock
module ptp_trigger_event_timestamp #(
  parameter int NUM_TRIG  = `PTP_NUM_TRIG,
  parameter int NUM_EVT   = `PTP_NUM_EVT,
  parameter int NUM_GPIO  = `PTP_NUM_GPIO,
  parameter int EVT_DEPTH = `PTP_EVT_DEPTH
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // Avalon-MM slave
  input  wire logic [7:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  // Precision time
  input  ptp_pkg::ptp_time_t       now,
  // GPIO pins
  input  wire logic [NUM_GPIO-1:0] gpio_in,
  output logic      [NUM_GPIO-1:0] gpio_out,
  output logic      [NUM_GPIO-1:0] gpio_oe,
  // Interrupts
  input  wire logic                other_irq,
  output logic                     powerdown_interrupt_pin_n
);
  localparam int EW = $bits(ptp_pkg::evt_entry_t);
  localparam int CW = $clog2(EVT_DEPTH) + 1;

  // Bus state
  logic        wait_reg;
  logic [31:0] readdata_reg;
  logic [31:0] rd_mux;

  // Software registers
  logic [31:0]          ctrl_reg;
  ptp_pkg::trig_time_t  tdata_reg;
  ptp_pkg::trig_cfg_t   tcfg_reg [NUM_TRIG];
  ptp_pkg::evt_cfg_t    ecfg_reg [NUM_EVT];

  // Pin and event state
  logic [NUM_GPIO-1:0]   gpio_out_reg, gpio_oe_reg;
  logic [NUM_GPIO-1:0]   pin_prev_reg;
  logic                  int_pin_reg;
  logic [`PTP_MISSED_W-1:0] missed_reg, missed_next;

  // Bus decode
  wire        req      = avs_read || avs_write;
  wire        ack      = req && !wait_reg;
  wire        wr_ack   = ack && avs_write;
  wire        rd_ack   = ack && avs_read;
  wire [2:0]  region   = avs_address[7:5];
  wire [2:0]  idx      = avs_address[4:2];
  wire        in_tcfg  = (region == `PTP_REGION_TCFG) && (32'(idx) < NUM_TRIG);
  wire        in_ecfg  = (region == `PTP_REGION_ECFG) && (32'(idx) < NUM_EVT);
  wire        wr_ctrl  = wr_ack && (avs_address == `PTP_OFS_CTRL);
  wire        trig_ld  = wr_ctrl && avs_writedata[`PTP_CTRL_LOAD_BIT];
  wire [2:0]  trig_sel = avs_writedata[2:0];
  wire        pop_evt  = rd_ack && (avs_address == `PTP_OFS_ENS);

  // Control fields
  wire        irq_on_gpio = ctrl_reg[`PTP_CTRL_IRQG_BIT];
  wire [3:0]  irq_pin     = ctrl_reg[`PTP_CTRL_IRQP_LSB +: 4];

  // Trigger and queue wires
  logic [NUM_TRIG-1:0]  trig_level, trig_armed;
  logic [NUM_TRIG-1:0]  on_pin [NUM_GPIO];
  logic [NUM_GPIO-1:0]  pin_drive, pin_used;
  logic [NUM_EVT-1:0]   evt_hit, evt_dir;
  logic [2:0]           first_chan;
  logic                 fifo_full, fifo_empty;
  logic [CW-1:0]        fifo_count;
  ptp_pkg::evt_entry_t  push_entry, head_entry;
  logic [EW-1:0]        head_bits;

  // Bus handshake: each request waits one cycle, then completes
  always_ff @(posedge clk)
  begin
    if (!nrst)
      wait_reg <= 1'b1;
    else
      wait_reg <= !(req && wait_reg);
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      readdata_reg <= 32'h0;
    else if (req && wait_reg)
      readdata_reg <= rd_mux;
  end

  // Control and time data registers, kept apart from the per-trigger config
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ctrl_reg  <= `PTP_CTRL_RST;
      tdata_reg <= '0;
    end
    else if (wr_ack)
    begin
      case (avs_address)
        `PTP_OFS_CTRL:    ctrl_reg <= avs_writedata & 32'h0000_f100;
        `PTP_OFS_TSEC:    tdata_reg.sec <= avs_writedata;
        `PTP_OFS_TNS:     tdata_reg.ns <= avs_writedata[29:0];
        `PTP_OFS_TWIDTH:  tdata_reg.width <= avs_writedata;
        `PTP_OFS_TPERIOD: tdata_reg.period <= avs_writedata;
        default:          ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // Per-trigger channels with their config registers
  genvar t;
  generate
    for (t = 0; t < NUM_TRIG; t++)
    begin : g_trig
      always_ff @(posedge clk)
      begin
        if (!nrst)
          tcfg_reg[t] <= `PTP_CFG_RST;
        else if (wr_ack && in_tcfg && idx == 3'(t))
          tcfg_reg[t] <= avs_writedata[7:0];
      end

      ptp_trig_channel u_trig (
        .clk   (clk),
        .nrst  (nrst),
        .now   (now),
        .cfg   (tcfg_reg[t]),
        .tdata (tdata_reg),
        .load  (trig_ld && trig_sel == 3'(t)),
        .level (trig_level[t]),
        .armed (trig_armed[t])
      );
    end
  endgenerate

  // Pin combine: any trigger may land on any pin; shared pins OR
  genvar p, q;
  generate
    for (p = 0; p < NUM_GPIO; p++)
    begin : g_pin
      for (q = 0; q < NUM_TRIG; q++)
      begin : g_map
        assign on_pin[p][q] = tcfg_reg[q].enable && (tcfg_reg[q].pin == 4'(p));
      end
      assign pin_used[p]  = (|on_pin[p]) || (irq_on_gpio && irq_pin == 4'(p));
      assign pin_drive[p] = (|(trig_level & on_pin[p]))
                            || (irq_on_gpio && irq_pin == 4'(p) && !fifo_empty);
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      gpio_out_reg <= '0;
      gpio_oe_reg  <= '0;
      pin_prev_reg <= '0;
      int_pin_reg  <= 1'b1;
    end
    else
    begin
      gpio_out_reg <= pin_drive;
      gpio_oe_reg  <= pin_used;
      pin_prev_reg <= gpio_in;
      // Shared pin keeps the other sources even when event ready goes to a GPIO
      int_pin_reg  <= !(other_irq || (!irq_on_gpio && !fifo_empty));
    end
  end

  // Event edge detection per channel
  genvar e;
  generate
    for (e = 0; e < NUM_EVT; e++)
    begin : g_evt
      wire       pin_ok = (32'(ecfg_reg[e].pin) < NUM_GPIO);
      wire       cur    = pin_ok && gpio_in[ecfg_reg[e].pin];
      wire       prv    = pin_ok && pin_prev_reg[ecfg_reg[e].pin];
      always_ff @(posedge clk)
      begin
        if (!nrst)
          ecfg_reg[e] <= `PTP_CFG_RST;
        else if (wr_ack && in_ecfg && idx == 3'(e))
          ecfg_reg[e] <= avs_writedata[7:0];
      end
      assign evt_hit[e] = ecfg_reg[e].enable && pin_ok
                          && ((ecfg_reg[e].rise && cur && !prv) || (ecfg_reg[e].fall && !cur && prv));
      assign evt_dir[e] = cur;
    end
  endgenerate

  // Lowest channel wins a cycle with several events
  always_comb
  begin
    first_chan = 3'h0;
    for (int c = NUM_EVT - 1; c >= 0; c--)
    begin
      if (evt_hit[c])
        first_chan = 3'(c);
    end
  end

  wire any_hit   = |evt_hit;
  wire multi_hit = |(evt_hit & (evt_hit - 1'b1));
  wire lost_evt  = any_hit && (fifo_full || multi_hit);

  assign push_entry.chan = first_chan;
  assign push_entry.rise = evt_dir[first_chan];
  assign push_entry.sec  = now.sec;
  assign push_entry.ns   = now.ns;

  ptp_event_fifo #(
    .WIDTH (EW),
    .DEPTH (EVT_DEPTH)
  ) u_fifo (
    .clk   (clk),
    .nrst  (nrst),
    .push  (any_hit),
    .wdata (push_entry),
    .pop   (pop_evt),
    .rdata (head_bits),
    .full  (fifo_full),
    .empty (fifo_empty),
    .count (fifo_count)
  );

  assign head_entry = head_bits;

  // Missed counter saturates; a loss in the pop cycle survives the clear
  always_comb
  begin
    missed_next = missed_reg;
    if (pop_evt && !fifo_empty)
      missed_next = `PTP_MISSED_W'(lost_evt);
    else if (lost_evt && missed_reg != '1)
      missed_next = missed_reg + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      missed_reg <= '0;
    else
      missed_reg <= missed_next;
  end

  // Read mux
  always_comb
  begin
    rd_mux = 32'h0;
    if (in_tcfg)
      rd_mux = {24'h0, tcfg_reg[idx]};
    else if (in_ecfg)
      rd_mux = {24'h0, ecfg_reg[idx]};
    else
    begin
      case (avs_address)
        `PTP_OFS_CTRL:    rd_mux = ctrl_reg;
        `PTP_OFS_TSEC:    rd_mux = tdata_reg.sec;
        `PTP_OFS_TNS:     rd_mux = {2'b00, tdata_reg.ns};
        `PTP_OFS_TWIDTH:  rd_mux = tdata_reg.width;
        `PTP_OFS_TPERIOD: rd_mux = tdata_reg.period;
        `PTP_OFS_TSTAT:   rd_mux = {16'h0, 8'(trig_level), 8'(trig_armed)};
        `PTP_OFS_PSTAT:
        begin
          rd_mux[`PTP_PSTAT_RDY_BIT] = !fifo_empty;
          rd_mux[`PTP_PSTAT_CNT_LSB +: CW] = fifo_count;
        end
        `PTP_OFS_ESTAT:
        begin
          rd_mux[2:0] = fifo_empty ? 3'h0 : head_entry.chan;
          rd_mux[`PTP_ESTAT_DIR_BIT] = !fifo_empty && head_entry.rise;
          rd_mux[`PTP_ESTAT_MISS_LSB +: `PTP_MISSED_W] = missed_reg;
          rd_mux[`PTP_ESTAT_VLD_BIT] = !fifo_empty;
        end
        `PTP_OFS_ESEC:    rd_mux = fifo_empty ? 32'h0 : head_entry.sec;
        `PTP_OFS_ENS:     rd_mux = fifo_empty ? 32'h0 : {2'b00, head_entry.ns};
        default:          rd_mux = 32'h0;
      endcase
    end
  end

  assign avs_readdata              = readdata_reg;
  assign avs_waitrequest           = wait_reg;
  assign gpio_out                  = gpio_out_reg;
  assign gpio_oe                   = gpio_oe_reg;
  assign powerdown_interrupt_pin_n = int_pin_reg;

  bus_answer_a: assert property (@(posedge clk) disable iff (!nrst)
    (req && wait_reg) |=> !wait_reg ##1 wait_reg)
    else $error("bus access not answered after one wait cycle");

  ready_flag_a: assert property (@(posedge clk) disable iff (!nrst)
    (avs_read && wait_reg && avs_address == `PTP_OFS_PSTAT) |=> (avs_readdata[0] == $past(!fifo_empty)))
    else $error("event ready flag disagrees with queue");

  pop_read_a: assert property (@(posedge clk) disable iff (!nrst)
    (pop_evt && !fifo_empty && !any_hit) |=> (fifo_count == $past(fifo_count) - 1'b1))
    else $error("timestamp read did not remove entry");

  drop_count_a: assert property (@(posedge clk) disable iff (!nrst)
    (fifo_full && any_hit && !pop_evt) |=> (fifo_count == $past(fifo_count)) && (missed_reg != '0))
    else $error("overflow not dropped or not counted");

  evt_capture_a: assert property (@(posedge clk) disable iff (!nrst)
    (any_hit && !fifo_full && !pop_evt) |=> (fifo_count == $past(fifo_count) + 1'b1))
    else $error("detected edge not queued");

  pin_or_a: assert property (@(posedge clk) disable iff (!nrst)
    (!irq_on_gpio) |=> (gpio_out_reg[0] == $past(|(trig_level & on_pin[0]))))
    else $error("pin 0 is not the OR of its triggers");

  irq_route_a: assert property (@(posedge clk) disable iff (!nrst)
    (!fifo_empty && !irq_on_gpio) |=> !powerdown_interrupt_pin_n)
    else $error("event ready not on shared interrupt pin");

  irq_gpio_a: assert property (@(posedge clk) disable iff (!nrst)
    (irq_on_gpio && !other_irq && 32'(irq_pin) < NUM_GPIO) |=> powerdown_interrupt_pin_n && gpio_oe_reg[$past(irq_pin)])
    else $error("GPIO interrupt route not honoured");
endmodule

// File: ptp_tev_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the trigger/event block
// Assumes: 32-bit Avalon-MM word registers at byte offsets
// Notes: Definitions only
`ifndef PTP_TEV_DEFINES_SVH
`define PTP_TEV_DEFINES_SVH

// Timing
`define PTP_CLK_PERIOD_NS   4
`define PTP_NS_PER_CLK      (`PTP_CLK_PERIOD_NS)
`define PTP_EVT_CORR_NS     35

// Sizes
`define PTP_NUM_TRIG        8
`define PTP_NUM_EVT         8
`define PTP_NUM_GPIO        12
`define PTP_EVT_DEPTH       8
`define PTP_MISSED_W        4

// Register byte offsets
`define PTP_OFS_CTRL        8'h00
`define PTP_OFS_TSEC        8'h04
`define PTP_OFS_TNS         8'h08
`define PTP_OFS_TWIDTH      8'h0c
`define PTP_OFS_TPERIOD     8'h10
`define PTP_OFS_TSTAT       8'h14
`define PTP_OFS_PSTAT       8'h20
`define PTP_OFS_ESTAT       8'h24
`define PTP_OFS_ESEC        8'h28
`define PTP_OFS_ENS         8'h2c
`define PTP_REGION_TCFG     3'h2
`define PTP_REGION_ECFG     3'h3

// Field positions
`define PTP_CTRL_LOAD_BIT   4
`define PTP_CTRL_IRQG_BIT   8
`define PTP_CTRL_IRQP_LSB   12
`define PTP_PSTAT_RDY_BIT   0
`define PTP_PSTAT_CNT_LSB   8
`define PTP_ESTAT_DIR_BIT   3
`define PTP_ESTAT_MISS_LSB  4
`define PTP_ESTAT_VLD_BIT   8

// Reset values
`define PTP_CTRL_RST        32'h0000_0000
`define PTP_CFG_RST         8'h00
`define PTP_TDATA_RST       32'h0000_0000

`endif

// File: ptp_pkg.sv
// Purpose: Types shared by the trigger/event block
// Assumes: Field layouts match the defines header
// Notes: None
package ptp_pkg;

  typedef struct packed {
    logic [31:0] sec;
    logic [29:0] ns;
    logic [31:0] frac;
  } ptp_time_t;

  typedef enum logic [1:0] {
    MODE_EDGE     = 2'b00,
    MODE_PULSE    = 2'b01,
    MODE_PERIODIC = 2'b10
  } trig_mode_t;

  typedef enum logic [1:0] {
    TRG_IDLE   = 2'b00,
    TRG_ARMED  = 2'b01,
    TRG_ACTIVE = 2'b10,
    TRG_DONE   = 2'b11
  } trig_state_t;

  typedef struct packed {
    logic [3:0] pin;
    logic       invert;
    trig_mode_t mode;
    logic       enable;
  } trig_cfg_t;

  typedef struct packed {
    logic [3:0] pin;
    logic       spare;
    logic       fall;
    logic       rise;
    logic       enable;
  } evt_cfg_t;

  typedef struct packed {
    logic [31:0] sec;
    logic [29:0] ns;
    logic [31:0] width;
    logic [31:0] period;
  } trig_time_t;

  typedef struct packed {
    logic [2:0]  chan;
    logic        rise;
    logic [31:0] sec;
    logic [29:0] ns;
  } evt_entry_t;

endpackage

// File: ptp_trig_channel.sv
// Purpose: One time-compare trigger channel
// Assumes: now advances by one clock period of nanoseconds per cycle
// Notes: Fractional nanoseconds take no part in the compare
`timescale 1ns/1ns
`include "ptp_tev_defines.svh"
module ptp_trig_channel (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               nrst,
  // Time and setup
  input  ptp_pkg::ptp_time_t      now,
  input  ptp_pkg::trig_cfg_t      cfg,
  input  ptp_pkg::trig_time_t     tdata,
  input  wire logic               load,
  // Result
  output logic                    level,
  output logic                    armed
);
  ptp_pkg::trig_state_t state_reg, state_next;
  ptp_pkg::trig_time_t  tim_reg;
  logic [31:0]          phase_reg, phase_next;
  logic                 level_reg, level_next;
  wire  [31:0]          phase_inc = phase_reg + 32'(`PTP_NS_PER_CLK);
  wire                  match = (now.sec == tim_reg.sec) && (now.ns == tim_reg.ns);
  wire                  periodic = (cfg.mode == ptp_pkg::MODE_PERIODIC);

  always_comb
  begin
    state_next = state_reg;
    phase_next = phase_reg;
    if (load)
    begin
      state_next = ptp_pkg::TRG_ARMED;
    end
    else
    begin
      case (state_reg)
        ptp_pkg::TRG_IDLE: state_next = ptp_pkg::TRG_IDLE;
        ptp_pkg::TRG_ARMED:
        begin
          phase_next = 32'h0;
          if (!cfg.enable)
            state_next = ptp_pkg::TRG_IDLE;
          else if (match)
            state_next = (cfg.mode == ptp_pkg::MODE_EDGE) ? ptp_pkg::TRG_DONE : ptp_pkg::TRG_ACTIVE;
        end
        ptp_pkg::TRG_ACTIVE:
        begin
          if (!cfg.enable)
            state_next = ptp_pkg::TRG_IDLE;
          else if (periodic && phase_inc >= tim_reg.period)
            phase_next = 32'h0;
          else if (!periodic && phase_inc >= tim_reg.width)
            state_next = ptp_pkg::TRG_DONE;
          else
            phase_next = phase_inc;
        end
        ptp_pkg::TRG_DONE: state_next = cfg.enable ? ptp_pkg::TRG_DONE : ptp_pkg::TRG_IDLE;
        default: state_next = ptp_pkg::TRG_IDLE;
      endcase
    end
    // Edge mode holds its new level until the channel is disabled or re-armed
    level_next = cfg.invert ^ (((state_next == ptp_pkg::TRG_ACTIVE) && (!periodic || phase_next < tim_reg.width))
                 || ((state_next == ptp_pkg::TRG_DONE) && (cfg.mode == ptp_pkg::MODE_EDGE)));
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_reg <= ptp_pkg::TRG_IDLE;
      phase_reg <= 32'h0;
      level_reg <= 1'b0;
      tim_reg   <= '0;
    end
    else
    begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      level_reg <= level_next;
      if (load)
        tim_reg <= tdata;
    end
  end

  assign level = level_reg;
  assign armed = (state_reg == ptp_pkg::TRG_ARMED);

  edge_fire_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_reg == ptp_pkg::TRG_ARMED && cfg.enable && match && !load && cfg.mode == ptp_pkg::MODE_EDGE)
    |=> (state_reg == ptp_pkg::TRG_DONE) && (level_reg == !$past(cfg.invert)))
    else $error("edge trigger did not fire on time match");
endmodule

// File: ptp_event_fifo.sv
// Purpose: Timestamp queue with registered read data
// Assumes: DEPTH is a power of two
// Notes: Read data trail a push into an empty queue by one cycle
`timescale 1ns/1ns
module ptp_event_fifo #(
  parameter int WIDTH = 66,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     nrst,
  // Fill side
  input  wire logic                     push,
  input  wire logic [WIDTH-1:0]         wdata,
  // Drain side
  input  wire logic                     pop,
  output logic      [WIDTH-1:0]         rdata,
  output logic                          full,
  output logic                          empty,
  output logic      [$clog2(DEPTH):0]   count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    rd_ptr_reg, wr_ptr_reg;
  logic [AW:0]      count_reg;
  logic [WIDTH-1:0] rdata_reg;
  wire              do_push = push && !full;
  wire              do_pop  = pop && !empty;
  wire  [AW-1:0]    rd_ptr_next = rd_ptr_reg + AW'(do_pop);

  always_ff @(posedge clk)
  begin
    if (do_push)
      mem[wr_ptr_reg] <= wdata;
    rdata_reg <= mem[rd_ptr_next];
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rd_ptr_reg <= '0;
      wr_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      rd_ptr_reg <= rd_ptr_next;
      wr_ptr_reg <= wr_ptr_reg + AW'(do_push);
      count_reg  <= count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  assign full  = (count_reg == (AW+1)'(DEPTH));
  assign empty = (count_reg == '0);
  assign count = count_reg;
  assign rdata = rdata_reg;

  fifo_count_a: assert property (@(posedge clk) disable iff (!nrst)
    (do_push && !do_pop) |=> (count_reg == $past(count_reg) + 1'b1) && (count_reg <= (AW+1)'(DEPTH)))
    else $error("queue count wrong after push");
endmodule

// File: ptp_far_side.sv
// Purpose: Precision clock and external pin source facing the block
// Assumes: Time steps 4 ns per clock from reset
// Notes: Fractions are noise, the block never compares them
`timescale 1ns/1ns
module ptp_far_side (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // Pin control
  input  wire logic [11:0]   flip,
  output logic      [11:0]   pins,
  // Time
  output ptp_pkg::ptp_time_t now
);
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      now  <= '{sec: 32'h0000_0007, ns: 30'h0, frac: 32'h0};
      pins <= 12'h000;
    end
    else
    begin
      now.ns   <= now.ns + 30'h4;
      now.frac <= $random;
      pins     <= pins ^ flip;
    end
  end
endmodule

// File: tb_ptp_trigger_event_timestamp.sv
// Purpose: Self-checking bench of the trigger/event block
// Assumes: Every bus access waits for waitrequest low
// Notes: Seeded random pins and channels
`timescale 1ns/1ns
module tb_ptp_trigger_event_timestamp;
  logic               clk;
  logic               nrst;
  logic [7:0]         avs_address;
  logic               avs_read;
  logic               avs_write;
  logic [31:0]        avs_writedata;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  ptp_pkg::ptp_time_t now;
  logic [11:0]        gpio_in;
  logic [11:0]        gpio_out;
  logic [11:0]        gpio_oe;
  logic [11:0]        flip;
  logic               other_irq;
  logic               irq_n;
  int                 n_fail;
  int                 num_checks;
  int                 seed;
  logic [31:0]        q;
  logic [29:0]        stamps[$];

  ptp_trigger_event_timestamp ptp_trigger_event_timestamp_i (.clk(clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .now(now), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .other_irq(other_irq), .powerdown_interrupt_pin_n(irq_n));
  ptp_far_side ptp_far_side_i (.clk(clk), .nrst(nrst), .flip(flip), .pins(gpio_in), .now(now));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic report_and_stop;
    if (n_fail == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] exp_estat(input int miss, input logic dir, input int chan);
    return 32'h100 | 32'(miss) << 4 | 32'(dir) << 3 | 32'(chan);
  endfunction

  task automatic tick(inout int k);
    @(posedge clk);
    k++;
  endtask

  // Waits on waitrequest alone; a hang is cut by the watchdog
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop;
  end

  initial
  begin : main
    int pin, m, c, hi, lo, n;
    logic [29:0] act;
    seed = 61637;
    n_fail = 0;
    num_checks = 0;
    nrst = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    flip = 12'h000;
    other_irq = 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk({irq_n, gpio_oe}, 13'h1000);
    rd(8'h20, 32'h0);
    rd(8'h3c, 32'h0);
    other_irq <= 1'b1;
    repeat (2) @(posedge clk);
    chk(irq_n, 1'b0);
    other_irq <= 1'b0;
    repeat (2) @(posedge clk);
    // Edge, pulse of 12 ns, then periodic 12 ns high in 32 ns
    for (m = 0; m < 3; m++)
    begin
      pin = $unsigned($random(seed)) % 12;
      bus(1'b1, 8'h40 + 8'(4 * m), 32'(pin << 4 | m << 1 | 1));
      rd(8'h40 + 8'(4 * m), 32'(pin << 4 | m << 1 | 1));
      act = now.ns + 30'd240;
      bus(1'b1, 8'h04, 32'h7);
      bus(1'b1, 8'h08, 32'(act));
      bus(1'b1, 8'h0c, 32'hc);
      bus(1'b1, 8'h10, 32'h20);
      bus(1'b1, 8'h00, 32'(16 + m));
      while (now.ns !== act) @(posedge clk);
      n = 0;
      tick(n);
      while (gpio_out[pin] !== 1'b1 && n < 9) tick(n);
      chk(n, 2);
      chk(gpio_oe[pin], 1'b1);
      hi = 0;
      lo = 0;
      while (gpio_out[pin] === 1'b1 && hi < 20) tick(hi);
      while (gpio_out[pin] === 1'b0 && lo < 20) tick(lo);
      chk(hi, (m == 0) ? 20 : 3);
      if (m > 0)
        chk(lo, (m == 1) ? 20 : 5);
      bus(1'b1, 8'h40 + 8'(4 * m), 32'h0);
      repeat (2) @(posedge clk);
      chk(gpio_oe[pin], 1'b0);
    end
    // Two 8 ns pulses 8 ns apart on one pin merge into one 16 ns pulse
    pin = $unsigned($random(seed)) % 12;
    act = now.ns + 30'd400;
    for (m = 3; m < 5; m++)
    begin
      bus(1'b1, 8'h40 + 8'(4 * m), 32'(pin << 4 | 3));
      bus(1'b1, 8'h08, 32'(act + 30'(8 * (m - 3))));
      bus(1'b1, 8'h0c, 32'h8);
      bus(1'b1, 8'h00, 32'(16 + m));
    end
    rd(8'h14, 32'h18);
    while (now.ns !== act) @(posedge clk);
    n = 0;
    tick(n);
    while (gpio_out[pin] !== 1'b1 && n < 9) tick(n);
    chk(n, 2);
    hi = 0;
    while (gpio_out[pin] === 1'b1 && hi < 20) tick(hi);
    chk(hi, 4);
    bus(1'b1, 8'h4c, 32'h0);
    bus(1'b1, 8'h50, 32'h0);
    // Rise only, fall only, both: twelve toggles overflow the queue when both
    for (m = 1; m < 4; m++)
    begin
      pin = $unsigned($random(seed)) % 12;
      c = $unsigned($random(seed)) % 8;
      bus(1'b1, 8'h60 + 8'(4 * c), 32'(pin << 4 | m << 1 | 1));
      for (n = 0; n < 12; n++)
      begin
        flip[pin] <= 1'b1;
        @(posedge clk);
        flip[pin] <= 1'b0;
        @(posedge clk);
        if (m[n % 2])
          stamps.push_back(now.ns);
        @(posedge clk);
      end
      n = stamps.size();
      rd(8'h20, 32'(((n > 8) ? 8 : n) << 8 | 1));
      chk(irq_n, 1'b0);
      bus(1'b1, 8'h00, 32'(256 | ((pin + 1) % 12) << 12));
      repeat (2) @(posedge clk);
      chk({gpio_oe[(pin + 1) % 12], gpio_out[(pin + 1) % 12], irq_n}, 3'h7);
      bus(1'b1, 8'h00, 32'h0);
      for (hi = 0; hi < 8 && hi < n; hi++)
      begin
        rd(8'h24, exp_estat((hi == 0 && n > 8) ? n - 8 : 0, (m == 3) ? !hi[0] : m == 1, c));
        rd(8'h28, 32'h7);
        rd(8'h2c, 32'(stamps[hi]));
      end
      rd(8'h20, 32'h0);
      rd(8'h24, 32'h0);
      stamps.delete();
      bus(1'b1, 8'h60 + 8'(4 * c), 32'h0);
    end
    report_and_stop;
  end
endmodule
